// ===== rtl/adc_seq_pkg.sv
package adc_seq_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS        = 50;
  // Delay code 1 is the reference 50 us; other codes scale linearly
  localparam int START_DELAY_UNIT_NS  = 50000;
  localparam int START_DELAY_UNIT_CYC = (START_DELAY_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // How long the ready line stays low between back-to-back results
  localparam int READY_LOW_NS         = 2000;
  localparam int READY_LOW_CYC        = READY_LOW_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Serial frame
  // ----------------------------------------------------------------
  localparam logic [5:0] CMD_EDGE_PLAIN = 6'h10;
  localparam logic [5:0] CMD_EDGE_CHECK = 6'h20;
  localparam logic [5:0] OPCODE_EDGES   = 6'h08;
  localparam logic [5:0] EDGE_CNT_MAX   = 6'h3f;
  localparam logic [7:0] CMD_START      = 8'h08;
  localparam logic [7:0] CMD_STOP       = 8'h0a;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_MODE_CONFIG_ZERO = 4'h0;
  localparam logic [3:0] IDX_CONV_CTRL        = 4'h1;
  localparam logic [3:0] IDX_PERIOD           = 4'h2;
  localparam logic [3:0] IDX_IRQ_STATUS       = 4'h3;
  localparam logic [3:0] IDX_IRQ_MASK         = 4'h4;
  localparam logic [3:0] IDX_RESULT           = 4'h5;
  localparam logic [3:0] IDX_SEQ_STATE        = 4'h6;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int FILTER_LSB     = 0;
  localparam int CONV_MODE_BIT  = 4;
  localparam int DELAY_LSB      = 0;
  localparam int CHOP_BIT       = 4;
  localparam int ACX_BIT        = 5;
  localparam int CHECK_BIT      = 6;
  localparam int EV_READY_BIT   = 0;
  localparam int EV_RESTART_BIT = 1;
  localparam int EV_STOP_BIT    = 2;
  localparam int EV_W           = 3;

  localparam logic [2:0] FILTER_SINC1 = 3'h0;
  localparam logic [2:0] FILTER_SINC2 = 3'h1;
  localparam logic [2:0] FILTER_SINC3 = 3'h2;
  localparam logic [2:0] FILTER_SINC4 = 3'h3;
  localparam logic [2:0] FILTER_FIR   = 3'h4;
  localparam logic [2:0] FILTER_SINC5 = 3'h5;

  localparam logic [2:0] FILTER_RESET = FILTER_FIR;
  localparam logic [3:0] DELAY_RESET  = 4'h1;

  typedef enum logic [1:0] {
    SEQ_IDLE    = 2'b00,
    SEQ_DELAY   = 2'b01,
    SEQ_CONVERT = 2'b10
  } seq_state_t;

  // Number of data-rate periods before the filter output is settled
  function automatic logic [2:0] settle_periods(input logic [2:0] filter);
    case (filter)
      FILTER_SINC2: settle_periods = 3'h2;
      FILTER_SINC3: settle_periods = 3'h3;
      FILTER_SINC4: settle_periods = 3'h4;
      default:      settle_periods = 3'h1;
    endcase
  endfunction : settle_periods

endpackage : adc_seq_pkg

// ===== rtl/pin_sync.sv
module pin_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] level_o,
  output logic      [WIDTH-1:0] rise_o,
  output logic      [WIDTH-1:0] fall_o
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] stable;
  logic [WIDTH-1:0] prev;

  // The first stage feeds only the second; edges come from later stages
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta   <= '0;
      stable <= '0;
      prev   <= '0;
    end else begin
      meta   <= async_i;
      stable <= meta;
      prev   <= stable;
    end
  end

  assign level_o = stable;
  assign rise_o  = stable & ~prev;
  assign fall_o  = ~stable & prev;

endmodule : pin_sync

// ===== rtl/adc_conversion_sequencer.sv
// How it works
// - Conversions begin on a start pin rise or a serial start command.
// - Commands act on falling serial edge 16, or 32 with checksum on.
// - Continuous or single-shot comes from bit 4 of mode_config_zero.
// - Continuous mode converts back to back until a stop arrives.
// - result_ready_n goes high when a conversion is initiated.
// - result_ready_n goes low when the result is ready and readable.
// - Continuous stop lets the running conversion finish first.
// - A new start during a conversion restarts it from the beginning.
// - Single-shot: one conversion per start, then stop.
// - Single-shot: stop by pin or command does not abort.
// - FIR or sinc1 filter settles within one conversion period.
// - First latency is start delay plus settling plus overhead.
// - Later continuous results follow one data-rate period apart.
// - Chop or excitation: first latency doubles, then periods equal it.
// - Chop withholds first conversion; output is half opposite-phase difference.
// - Four-bit start-delay code; code 1 gives 50 microseconds.
module adc_conversion_sequencer #(
  parameter int          RESULT_W     = 24,
  parameter int          PERIOD_W     = 24,
  parameter int          OVERHEAD_CYC = 16,
  parameter logic [23:0] PERIOD_RESET = 24'hf4240
) (
  input  wire logic                core_clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                start_pin_i,
  input  wire logic                sclk_i,
  input  wire logic                cs_n_i,
  input  wire logic                mosi_i,
  input  wire logic [RESULT_W-1:0] conv_data_i,
  input  wire logic [3:0]          reg_addr_i,
  input  wire logic [31:0]         reg_wdata_i,
  input  wire logic                reg_we_i,
  input  wire logic                reg_re_i,
  output logic      [31:0]         reg_rdata_o,
  output logic                     result_ready_n_o,
  output logic                     chop_phase_o,
  output logic                     conv_busy_o,
  output logic                     irq_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sync_lvl;
  logic [3:0] sync_rise;
  logic [3:0] sync_fall;

  pin_sync #(.WIDTH(4)) u_pin_sync (
    .clk_i   (core_clk_i),
    .rst_n_i (rst_n_i),
    .async_i ({mosi_i, cs_n_i, sclk_i, start_pin_i}),
    .level_o (sync_lvl),
    .rise_o  (sync_rise),
    .fall_o  (sync_fall)
  );

  wire start_rise = sync_rise[0];
  wire start_fall = sync_fall[0];
  wire sclk_fall  = sync_fall[1];
  wire cs_active  = ~sync_lvl[2];
  wire mosi_bit   = sync_lvl[3];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [2:0]            filter_sel;
  logic                  conversion_mode_select;
  logic [3:0]            delay_code;
  logic                  chop_en;
  logic                  acx_en;
  logic                  check_en;
  logic [PERIOD_W-1:0]   period;
  logic [adc_seq_pkg::EV_W-1:0] irq_status;
  logic [adc_seq_pkg::EV_W-1:0] irq_mask;
  logic [RESULT_W-1:0]   result;

  // ----------------------------------------------------------------
  // Serial command framing
  // ----------------------------------------------------------------
  logic [5:0] edge_cnt;
  logic [7:0] opcode;

  wire [5:0] edge_next  = edge_cnt + 6'h01;
  wire [5:0] take_edge  = check_en ? adc_seq_pkg::CMD_EDGE_CHECK : adc_seq_pkg::CMD_EDGE_PLAIN;
  wire       cmd_take   = cs_active & sclk_fall & (edge_next == take_edge);
  wire       cmd_start  = cmd_take & (opcode == adc_seq_pkg::CMD_START);
  wire       cmd_stop   = cmd_take & (opcode == adc_seq_pkg::CMD_STOP);

  // Data is taken on the falling edge; a deselect drops a partial frame
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      edge_cnt <= 6'h00;
      opcode   <= 8'h00;
    end else if (!cs_active) begin
      edge_cnt <= 6'h00;
      opcode   <= 8'h00;
    end else if (sclk_fall) begin
      edge_cnt <= (edge_cnt == adc_seq_pkg::EDGE_CNT_MAX) ? edge_cnt : edge_next;
      if (edge_cnt < adc_seq_pkg::OPCODE_EDGES) begin
        opcode <= {opcode[6:0], mosi_bit};
      end
    end
  end

  // ----------------------------------------------------------------
  // Start and stop events
  // ----------------------------------------------------------------
  wire start_ev = start_rise | cmd_start;
  wire stop_ev  = start_fall | cmd_stop;
  wire single   = conversion_mode_select;

  // ----------------------------------------------------------------
  // Conversion lengths in core clock cycles
  // ----------------------------------------------------------------
  wire        chop_mode    = chop_en | acx_en;
  wire [2:0]  settle       = adc_seq_pkg::settle_periods(filter_sel);
  wire [31:0] delay_cyc    = 32'(delay_code) * 32'(adc_seq_pkg::START_DELAY_UNIT_CYC);
  wire [31:0] base_len     = 32'(settle) * 32'(period) + 32'(OVERHEAD_CYC);
  wire [31:0] normal_total = delay_cyc + base_len;
  // The chop first conversion holds a withheld half, so its total is doubled
  wire [31:0] first_len    = chop_mode ? normal_total + base_len : base_len;
  wire [31:0] next_len     = chop_mode ? normal_total : 32'(period);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  adc_seq_pkg::seq_state_t state;
  adc_seq_pkg::seq_state_t next_state;
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic        first;
  logic        next_first;
  logic        stop_pend;
  logic        next_stop_pend;

  wire conv_done  = (state == adc_seq_pkg::SEQ_CONVERT) && (cnt == 32'h1);
  wire chop_split = (state == adc_seq_pkg::SEQ_CONVERT) && chop_mode && first && (cnt == base_len);
  wire busy       = (state != adc_seq_pkg::SEQ_IDLE);

  always_comb begin
    next_state     = state;
    next_cnt       = cnt;
    next_first     = first;
    next_stop_pend = stop_pend;
    case (state)
      adc_seq_pkg::SEQ_IDLE: begin
        next_stop_pend = 1'b0;
      end
      adc_seq_pkg::SEQ_DELAY: begin
        if (cnt <= 32'h1) begin
          next_state = adc_seq_pkg::SEQ_CONVERT;
          next_cnt   = first_len;
        end else begin
          next_cnt = cnt - 32'h1;
        end
      end
      adc_seq_pkg::SEQ_CONVERT: begin
        if (conv_done) begin
          if (single || stop_pend) begin
            next_state = adc_seq_pkg::SEQ_IDLE;
          end else begin
            next_cnt   = next_len;
            next_first = 1'b0;
          end
        end else begin
          next_cnt = cnt - 32'h1;
        end
      end
      default: begin
        next_state = adc_seq_pkg::SEQ_IDLE;
      end
    endcase
    // Single-shot ignores stop so the running result always arrives
    if (stop_ev && busy && !single) begin
      next_stop_pend = 1'b1;
    end
    if (start_ev) begin
      next_first     = 1'b1;
      next_stop_pend = 1'b0;
      if (delay_cyc == 32'h0) begin
        next_state = adc_seq_pkg::SEQ_CONVERT;
        next_cnt   = first_len;
      end else begin
        next_state = adc_seq_pkg::SEQ_DELAY;
        next_cnt   = delay_cyc;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state     <= adc_seq_pkg::SEQ_IDLE;
      cnt       <= 32'h0;
      first     <= 1'b0;
      stop_pend <= 1'b0;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      first     <= next_first;
      stop_pend <= next_stop_pend;
    end
  end

  // ----------------------------------------------------------------
  // Ready indicator
  // ----------------------------------------------------------------
  // Between back-to-back results the line returns high after a short hold
  logic [15:0] ready_hold;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_ready_n_o <= 1'b1;
      ready_hold       <= 16'h0;
    end else if (start_ev) begin
      result_ready_n_o <= 1'b1;
      ready_hold       <= 16'h0;
    end else if (conv_done) begin
      result_ready_n_o <= 1'b0;
      ready_hold       <= 16'(adc_seq_pkg::READY_LOW_CYC);
    end else if (ready_hold != 16'h0) begin
      ready_hold <= ready_hold - 16'h1;
      if ((ready_hold == 16'h1) && (state == adc_seq_pkg::SEQ_CONVERT)) begin
        result_ready_n_o <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Result capture and chop arithmetic
  // ----------------------------------------------------------------
  logic [RESULT_W-1:0] prev_raw;
  logic                phase;

  wire signed [RESULT_W:0] diff    = phase ? ($signed({prev_raw[RESULT_W-1], prev_raw})
                                              - $signed({conv_data_i[RESULT_W-1], conv_data_i}))
                                           : ($signed({conv_data_i[RESULT_W-1], conv_data_i})
                                              - $signed({prev_raw[RESULT_W-1], prev_raw}));
  wire        [RESULT_W:0] half    = diff >>> 1;
  wire [RESULT_W-1:0]      out_val = chop_mode ? half[RESULT_W-1:0] : conv_data_i;

  // Phase restarts at each start so the withheld half is always positive
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_raw <= '0;
      phase    <= 1'b0;
      result   <= '0;
    end else if (start_ev) begin
      phase <= 1'b0;
    end else if (chop_split) begin
      prev_raw <= conv_data_i;
      phase    <= ~phase;
    end else if (conv_done) begin
      result   <= out_val;
      prev_raw <= conv_data_i;
      phase    <= ~phase;
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  wire wr_mode   = reg_we_i && (reg_addr_i == adc_seq_pkg::IDX_MODE_CONFIG_ZERO);
  wire wr_ctrl   = reg_we_i && (reg_addr_i == adc_seq_pkg::IDX_CONV_CTRL);
  wire wr_period = reg_we_i && (reg_addr_i == adc_seq_pkg::IDX_PERIOD);
  wire wr_status = reg_we_i && (reg_addr_i == adc_seq_pkg::IDX_IRQ_STATUS);
  wire wr_mask   = reg_we_i && (reg_addr_i == adc_seq_pkg::IDX_IRQ_MASK);

  wire [adc_seq_pkg::EV_W-1:0] events = {stop_ev & busy & ~single, start_ev & busy, conv_done};
  wire [adc_seq_pkg::EV_W-1:0] w1c    = wr_status ? reg_wdata_i[adc_seq_pkg::EV_W-1:0] : '0;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      filter_sel             <= adc_seq_pkg::FILTER_RESET;
      conversion_mode_select <= 1'b0;
      delay_code             <= adc_seq_pkg::DELAY_RESET;
      chop_en                <= 1'b0;
      acx_en                 <= 1'b0;
      check_en               <= 1'b0;
      period                 <= PERIOD_W'(PERIOD_RESET);
      irq_mask               <= '0;
    end else begin
      if (wr_mode) begin
        filter_sel             <= reg_wdata_i[adc_seq_pkg::FILTER_LSB +: 3];
        conversion_mode_select <= reg_wdata_i[adc_seq_pkg::CONV_MODE_BIT];
      end
      if (wr_ctrl) begin
        delay_code <= reg_wdata_i[adc_seq_pkg::DELAY_LSB +: 4];
        chop_en    <= reg_wdata_i[adc_seq_pkg::CHOP_BIT];
        acx_en     <= reg_wdata_i[adc_seq_pkg::ACX_BIT];
        check_en   <= reg_wdata_i[adc_seq_pkg::CHECK_BIT];
      end
      if (wr_period) begin
        period <= reg_wdata_i[PERIOD_W-1:0];
      end
      if (wr_mask) begin
        irq_mask <= reg_wdata_i[adc_seq_pkg::EV_W-1:0];
      end
    end
  end

  // A new event in the clearing cycle survives the clear
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~w1c) | events;
    end
  end

  wire [31:0] rd_mode  = {27'h0, conversion_mode_select, 1'b0, filter_sel};
  wire [31:0] rd_ctrl  = {25'h0, check_en, acx_en, chop_en, delay_code};
  wire [31:0] rd_state = {26'h0, stop_pend, first, phase, result_ready_n_o, state};

  logic [31:0] rd_mux;

  always_comb begin
    case (reg_addr_i)
      adc_seq_pkg::IDX_MODE_CONFIG_ZERO: rd_mux = rd_mode;
      adc_seq_pkg::IDX_CONV_CTRL:        rd_mux = rd_ctrl;
      adc_seq_pkg::IDX_PERIOD:           rd_mux = 32'(period);
      adc_seq_pkg::IDX_IRQ_STATUS:       rd_mux = 32'(irq_status);
      adc_seq_pkg::IDX_IRQ_MASK:         rd_mux = 32'(irq_mask);
      adc_seq_pkg::IDX_RESULT:           rd_mux = 32'(result);
      adc_seq_pkg::IDX_SEQ_STATE:        rd_mux = rd_state;
      default:                           rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 32'h0;
    end else begin
      reg_rdata_o <= reg_re_i ? rd_mux : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conv_busy_o  <= 1'b0;
      chop_phase_o <= 1'b0;
      irq_o        <= 1'b0;
    end else begin
      conv_busy_o  <= busy;
      chop_phase_o <= phase & chop_mode;
      irq_o        <= |(((irq_status & ~w1c) | events) & irq_mask);
    end
  end

endmodule : adc_conversion_sequencer

// ===== verification/adc_seq_checker_properties.sv
module adc_seq_checker (
  input wire logic        core_clk_i,
  input wire logic        rst_n_i,
  input wire logic        start_pin_i,
  input wire logic        sclk_i,
  input wire logic        cs_n_i,
  input wire logic [3:0]  reg_addr_i,
  input wire logic        reg_re_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        result_ready_n_o,
  input wire logic        conv_busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // ----------------------------------------------------------------
  // Cause tracker
  // ----------------------------------------------------------------
  // Raw samples lead the design's synchroniser, so a quiet window is a safe bound
  logic       sclk_q;
  logic [5:0] fall_cnt;
  logic [3:0] quiet;
  wire        sclk_fall = sclk_q & ~sclk_i & ~cs_n_i;
  wire        calm      = ~start_pin_i & (cs_n_i | (fall_cnt < 6'h0e));

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_q   <= 1'b0;
      fall_cnt <= 6'h00;
      quiet    <= 4'h0;
    end else begin
      sclk_q   <= sclk_i;
      fall_cnt <= cs_n_i ? 6'h00 : fall_cnt + {5'h00, sclk_fall};
      quiet    <= !calm ? 4'h0 : ((quiet == 4'hf) ? quiet : quiet + 4'h1);
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_read_zero_idle: assert property (!$past(reg_re_i) |-> reg_rdata_o == 32'h0)
    else $error("read data not zero outside a read answer");
  a_unmapped_read: assert property ($past(reg_re_i) && ($past(reg_addr_i) > 4'h6) |-> reg_rdata_o == 32'h0)
    else $error("unmapped index returned data");
  a_start_to_busy: assert property ($rose(start_pin_i) && !conv_busy_o |-> ##[3:6] conv_busy_o)
    else $error("start pin rise did not start a conversion");
  a_busy_has_cause: assert property ($rose(conv_busy_o) |-> quiet < 4'h8)
    else $error("conversion began without a start");
  a_ready_high_start: assert property ($rose(conv_busy_o) |-> result_ready_n_o && $past(result_ready_n_o))
    else $error("ready line not high when conversion began");
  a_ready_low_hold: assert property ($fell(result_ready_n_o) |-> !result_ready_n_o [*8])
    else $error("ready pulse too short");
  a_idle_ready_low: assert property ($fell(conv_busy_o) |-> !result_ready_n_o)
    else $error("went idle without a result");
  a_no_early_cmd: assert property (!conv_busy_o && !result_ready_n_o && (quiet > 4'h4) |=> !result_ready_n_o)
    else $error("conversion started before the command edge");
endmodule : adc_seq_checker

bind adc_conversion_sequencer adc_seq_checker i_adc_seq_checker (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .start_pin_i(start_pin_i), .sclk_i(sclk_i),
  .cs_n_i(cs_n_i), .reg_addr_i(reg_addr_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
  .result_ready_n_o(result_ready_n_o), .conv_busy_o(conv_busy_o)
);

// ===== verification/adc_host_model.sv
module adc_host_model (
  input  wire logic core_clk_i,
  output logic      start_pin_o,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Serial clock rests low between frames; the pin starts low
  initial begin
    start_pin_o = 1'b0;
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  task automatic pin(input logic v);
    @(posedge core_clk_i);
    start_pin_o <= v;
  endtask : pin

  // Frames only while the start pin rests low, offset from the core edges
  task automatic open();
    @(posedge core_clk_i);
    start_pin_o <= 1'b0;
    #13;
    cs_n_o = 1'b0;
    #200;
  endtask : open

  // Opcode goes out first, most significant bit first, taken on falling edges
  task automatic clocks(input logic [7:0] op, input int first, input int n);
    for (int i = first; i < first + n; i++) begin
      mosi_o = (i < 8) ? op[7-i] : 1'b0;
      sclk_o = 1'b1;
      #200;
      sclk_o = 1'b0;
      #200;
    end
  endtask : clocks

  // A released data line shows no stale value
  task automatic close();
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
  endtask : close
endmodule : adc_host_model

// ===== verification/adc_conversion_sequencer_tb.sv
module adc_conversion_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic        core_clk_i, rst_n_i, start_pin_i, sclk_i, cs_n_i, mosi_i;
  logic [23:0] conv_data_i;
  logic [3:0]  reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, rv;
  logic        reg_we_i, reg_re_i, result_ready_n_o, chop_phase_o, conv_busy_o, irq_o;
  int          num_errors, cmp_count, cycles, n;
  logic [3:0]  rst_idx [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h7};
  logic [31:0] rst_val [5] = '{32'h4, 32'h1, 32'hf4240, 32'h0, 32'h0};
  logic [2:0]  flt [3] = '{adc_seq_pkg::FILTER_FIR, adc_seq_pkg::FILTER_SINC1, adc_seq_pkg::FILTER_SINC3};
  int          stl [3] = '{1, 1, 3};

  adc_conversion_sequencer #(.OVERHEAD_CYC(16)) i_adc_conversion_sequencer (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .start_pin_i(start_pin_i), .sclk_i(sclk_i),
    .cs_n_i(cs_n_i), .mosi_i(mosi_i), .conv_data_i(conv_data_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
    .result_ready_n_o(result_ready_n_o), .chop_phase_o(chop_phase_o), .conv_busy_o(conv_busy_o),
    .irq_o(irq_o)
  );
  adc_host_model i_adc_host_model (
    .core_clk_i(core_clk_i), .start_pin_o(start_pin_i), .sclk_o(sclk_i), .cs_n_o(cs_n_i), .mosi_o(mosi_i)
  );

  always #25 core_clk_i = ~core_clk_i;
  // Raw data flips sign with the chop polarity, so a correct half difference returns the magnitude
  always @(posedge core_clk_i) conv_data_i <= chop_phase_o ? 24'hedcbaa : 24'h123456;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Sampling offset from start to the first sample is a few cycles of synchroniser
  task automatic near(input string what, input int seen, input int exp);
    check(what, {31'h0, (seen >= exp + 2) && (seen <= exp + 8)}, 32'h1);
  endtask : near

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_we_i    <= 1'b1;
    @(posedge core_clk_i);
    reg_we_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_re_i   <= 1'b1;
    @(posedge core_clk_i);
    reg_re_i <= 1'b0;
    @(negedge core_clk_i);
    d = reg_rdata_o;
  endtask : rd

  // Counts edges until the ready line has gone high and then low again
  task automatic wait_fall(output int k);
    k = 0;
    while (result_ready_n_o !== 1'b1 && k < 4000) begin
      @(posedge core_clk_i);
      k++;
    end
    while (result_ready_n_o !== 1'b0 && k < 4000) begin
      @(posedge core_clk_i);
      k++;
    end
  endtask : wait_fall

  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    core_clk_i = 1'b0;
    rst_n_i = 1'b0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 32'h0;
    reg_we_i = 1'b0;
    reg_re_i = 1'b0;
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(negedge core_clk_i);
    check("ready after reset", result_ready_n_o, 32'h1);
    check("irq after reset", irq_o, 32'h0);
    for (int i = 0; i < 5; i++) begin
      rd(rst_idx[i], rv);
      check("reset value", rv, rst_val[i]);
    end
    wr(4'h2, 32'd60);
    wr(4'h1, 32'h0);
    wr(4'h4, 32'h7);
    for (int i = 0; i < 3; i++) begin
      wr(4'h0, {27'h0, 2'b10, flt[i]});
      i_adc_host_model.pin(1'b1);
      wait_fall(n);
      near("single latency", n, stl[i] * 60 + 16);
      i_adc_host_model.pin(1'b0);
      repeat (100) @(posedge core_clk_i);
      check("single stops", {conv_busy_o, result_ready_n_o}, 32'h0);
    end
    wr(4'h3, 32'h7);
    wr(4'h0, 32'h4);
    i_adc_host_model.pin(1'b1);
    wait_fall(n);
    wait_fall(n);
    check("continuous period", n, 32'd60);
    i_adc_host_model.pin(1'b0);
    wait_fall(n);
    check("stop completes", n, 32'd59);
    repeat (80) @(posedge core_clk_i);
    check("stopped", conv_busy_o, 32'h0);
    rd(4'h3, rv);
    check("status", rv, 32'h5);
    check("irq raised", irq_o, 32'h1);
    wr(4'h4, 32'h0);
    repeat (2) @(posedge core_clk_i);
    check("irq masked", irq_o, 32'h0);
    wr(4'h4, 32'h7);
    wr(4'h3, 32'h7);
    repeat (2) @(posedge core_clk_i);
    check("irq cleared", irq_o, 32'h0);
    rd(4'h5, rv);
    check("result", rv, 32'h00123456);
    wr(4'h1, 32'h10);
    i_adc_host_model.pin(1'b1);
    wait_fall(n);
    near("chop first latency", n, 152);
    wait_fall(n);
    check("chop period", n, 32'd76);
    rd(4'h5, rv);
    check("chop result", rv, 32'h00123456);
    i_adc_host_model.pin(1'b0);
    repeat (300) @(posedge core_clk_i);
    wr(4'h1, 32'h1);
    wr(4'h3, 32'h7);
    i_adc_host_model.pin(1'b1);
    repeat (300) @(posedge core_clk_i);
    i_adc_host_model.pin(1'b0);
    repeat (10) @(posedge core_clk_i);
    i_adc_host_model.pin(1'b1);
    wait_fall(n);
    near("restart latency", n, 1076);
    rd(4'h3, rv);
    check("restart flag", rv[1], 32'h1);
    i_adc_host_model.pin(1'b0);
    repeat (1200) @(posedge core_clk_i);
    for (int ck = 0; ck < 2; ck++) begin
      wr(4'h1, ck ? 32'h41 : 32'h01);
      wr(4'h0, 32'h14);
      wr(4'h3, 32'h7);
      i_adc_host_model.open();
      i_adc_host_model.clocks(adc_seq_pkg::CMD_START, 0, ck ? 31 : 15);
      repeat (10) @(posedge core_clk_i);
      check("before command edge", conv_busy_o, 32'h0);
      i_adc_host_model.clocks(adc_seq_pkg::CMD_START, ck ? 31 : 15, 1);
      i_adc_host_model.close();
      repeat (10) @(posedge core_clk_i);
      check("command started", conv_busy_o, 32'h1);
      i_adc_host_model.open();
      i_adc_host_model.clocks(adc_seq_pkg::CMD_STOP, 0, ck ? 32 : 16);
      i_adc_host_model.close();
      wait_fall(n);
      check("stop ignored", {31'h0, n < 4000}, 32'h1);
      repeat (60) @(posedge core_clk_i);
      check("one shot", {conv_busy_o, result_ready_n_o}, 32'h0);
      rd(4'h3, rv);
      check("single stop flag", rv[2], 32'h0);
    end
    conclude();
  end
endmodule : adc_conversion_sequencer_tb
